//--- reset_seq_regs.vh
// Constants for the reset timeout sequencer
`ifndef RESET_SEQ_REGS_VH
`define RESET_SEQ_REGS_VH

// Oscillator select encodings
`define OSC_LOW_POWER_CRYSTAL 2'b00
`define OSC_STANDARD_CRYSTAL 2'b01
`define OSC_HIGH_SPEED_CRYSTAL 2'b10
`define OSC_RC_MODE 2'b11

// Timing figures in their own units
`define POWERUP_DELAY_US 72000
`define BROWNOUT_MIN_DURATION_US 100
`define RC_CLK_HZ 25000000
// Cycle counts, the first two derived from the figures (clock taken in whole MHz, integer division, no rounding up)
`define POWERUP_DELAY_CYC ((`POWERUP_DELAY_US * (`RC_CLK_HZ / 1000000)))
`define BROWNOUT_MIN_CYC ((`BROWNOUT_MIN_DURATION_US * (`RC_CLK_HZ / 1000000)))
`define OSC_STARTUP_CYCLES 1024
`define CLEAR_FILTER_CYCLES 16

// Sequencer states
`define ST_HOLD 3'd0
`define ST_PWRUP 3'd1
`define ST_OST 3'd2
`define ST_RUN 3'd3
`define ST_BROWN 3'd4
`define ST_SLEEP 3'd5

`endif

//--- stable_filter.v
// Persistence filter that passes a level only after it has held steady
`timescale 1ns/100ps
`default_nettype none
module stable_filter #(
    parameter COUNT = 16,  // Cycles the input must hold
    parameter INIT = 1'b1  // Output level after reset
) (
    input wire core_clk,
    input wire nrst,
    input wire din,        // Already synchronous input
    output reg dout_ff     // Filtered level
);
    // ----------------------------------------
    // Persistence counter
    // ----------------------------------------
    reg [15:0] cnt_ff;  // Cycles the input has differed from the output
    // Any return to the held level restarts the count, so pulses are dropped
    always @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            cnt_ff <= 16'h0000;
            dout_ff <= INIT;
        end else if (din == dout_ff) begin
            cnt_ff <= 16'h0000;
        end else if (cnt_ff == COUNT[15:0] - 16'h0001) begin
            cnt_ff <= 16'h0000;
            dout_ff <= din;
        end else begin
            cnt_ff <= cnt_ff + 16'h0001;
        end
    end
endmodule
`default_nettype wire

//--- reset_timeout_sequencer.v
// Reset cause sorting and timeout sequencing for a small microcontroller
`timescale 1ns/100ps
`default_nettype none
`include "reset_seq_regs.vh"
module reset_timeout_sequencer #(
    parameter POWERUP_CYC = `POWERUP_DELAY_CYC,  // Power-up delay in cycles
    parameter BROWNOUT_CYC = `BROWNOUT_MIN_CYC,  // Least under-voltage duration
    parameter OST_CYC = `OSC_STARTUP_CYCLES,     // Oscillator start-up edges
    parameter FILTER_CYC = `CLEAR_FILTER_CYCLES  // Master-clear persistence
) (
    input wire core_clk,              // Internal RC clock
    input wire nrst,                  // Power-on detector, active low
    input wire master_clear_pin_n,    // Master-clear pin level, low resets
    output wire master_clear_pin_oe_n, // Pin driver enable, never drives
    output wire master_clear_pin_out, // Pin driver data, unused
    input wire undervoltage,          // Supply below brownout threshold
    input wire brownout_enable,       // Config: brown-out detection on
    input wire powerup_timer_en,      // Config: power-up timer on
    input wire [1:0] osc_select_bits, // Config: oscillator mode
    input wire osc_input_pin,         // Oscillator input pin
    input wire watchdog_timeout,      // Watchdog expiry pulse
    input wire sleeping,              // Core is asleep
    input wire irq_wake,              // Interrupt wake pulse while asleep
    input wire set_por_status,        // Software sets power-on status flag
    input wire set_bor_status,        // Software sets brown-out status flag
    output wire core_reset,           // Core held in reset
    output wire reset_regs,           // One-cycle load of reset state
    output wire keep_regs_invalid,    // Keep-class registers unknown
    output wire [2:0] reset_cause,    // Last cause code
    output wire timeout_flag,
    output wire powerdown_flag,
    output wire por_status,           // Power-on status, low after power-on
    output wire bor_status            // Brown-out status, low after brown-out
);
    // ----------------------------------------
    // Cause codes
    // ----------------------------------------
    localparam [2:0] C_POWERON = 3'd0;
    localparam [2:0] C_CLEAR_RUN = 3'd1;
    localparam [2:0] C_CLEAR_SLEEP = 3'd2;
    localparam [2:0] C_WDT_RESET = 3'd3;
    localparam [2:0] C_WDT_WAKE = 3'd4;
    localparam [2:0] C_BROWNOUT = 3'd5;
    localparam [2:0] C_IRQ_WAKE = 3'd6;

    // ----------------------------------------
    // Pin driver
    // ----------------------------------------
    // The pin is input only; a watchdog reset stays internal
    assign master_clear_pin_oe_n = 1'b1;
    assign master_clear_pin_out = 1'b0;

    // ----------------------------------------
    // Input synchronisers
    // ----------------------------------------
    reg [2:0] clr_sync_ff;  // Master-clear pin chain
    reg [2:0] uv_sync_ff;   // Under-voltage chain
    reg [2:0] osc_sync_ff;  // Oscillator pin chain
    reg clr_agreed_ff;      // Master-clear after stage two/three agree
    reg uv_agreed_ff;       // Under-voltage after agreement
    reg osc_agreed_ff;      // Oscillator level after agreement
    always @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            clr_sync_ff <= 3'b111;
            uv_sync_ff <= 3'b000;
            osc_sync_ff <= 3'b000;
            clr_agreed_ff <= 1'b1;
            uv_agreed_ff <= 1'b0;
            osc_agreed_ff <= 1'b0;
        end else begin
            clr_sync_ff <= {clr_sync_ff[1:0], master_clear_pin_n};
            uv_sync_ff <= {uv_sync_ff[1:0], undervoltage};
            osc_sync_ff <= {osc_sync_ff[1:0], osc_input_pin};
            // A change counts only when stages two and three agree
            if (clr_sync_ff[1] == clr_sync_ff[2]) begin
                clr_agreed_ff <= clr_sync_ff[2];
            end
            if (uv_sync_ff[1] == uv_sync_ff[2]) begin
                uv_agreed_ff <= uv_sync_ff[2];
            end
            if (osc_sync_ff[1] == osc_sync_ff[2]) begin
                osc_agreed_ff <= osc_sync_ff[2];
            end
        end
    end

    // ----------------------------------------
    // Master-clear glitch filter
    // ----------------------------------------
    wire clr_level_n;  // Filtered pin, low asks for reset
    stable_filter #(
        .COUNT(FILTER_CYC),
        .INIT(1'b1)
    ) u_clear_filter (
        .core_clk(core_clk),
        .nrst(nrst),
        .din(clr_agreed_ff),
        .dout_ff(clr_level_n)
    );

    reg clr_prev_ff;  // Filtered level one cycle ago
    wire clr_fall = clr_prev_ff & ~clr_level_n;
    // Osc edge detection on the agreed level only
    reg osc_prev_ff;
    wire osc_rise = osc_agreed_ff & ~osc_prev_ff;

    // ----------------------------------------
    // Brown-out qualification
    // ----------------------------------------
    reg [31:0] uv_cnt_ff;  // Cycles under-voltage has persisted
    reg brown_ff;          // Qualified brown-out, held until recovery
    // Counted on this RC clock so it works with no crystal yet
    always @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            uv_cnt_ff <= 32'h0000_0000;
            brown_ff <= 1'b0;
        end else if (!brownout_enable || !uv_agreed_ff) begin
            uv_cnt_ff <= 32'h0000_0000;
            brown_ff <= 1'b0;
        end else if (uv_cnt_ff >= BROWNOUT_CYC - 1) begin
            brown_ff <= 1'b1;
        end else begin
            uv_cnt_ff <= uv_cnt_ff + 32'h0000_0001;
        end
    end

    // ----------------------------------------
    // Mode decode
    // ----------------------------------------
    wire crystal_mode = (osc_select_bits != `OSC_RC_MODE);
    wire powerup_timer_on = powerup_timer_en | brownout_enable;
    wire wdt_reset = watchdog_timeout & ~sleeping;
    wire wdt_wake = watchdog_timeout & sleeping;
    wire clr_sleep = clr_fall & sleeping;
    wire clr_run = clr_fall & ~sleeping;

    // ----------------------------------------
    // Sequencer state
    // ----------------------------------------
    reg [2:0] state_ff;
    reg [2:0] nxt_state;
    reg [31:0] cnt_ff;      // Power-up delay count
    reg [31:0] nxt_cnt;
    reg [10:0] ost_cnt_ff;  // Oscillator edges counted
    reg [10:0] nxt_ost_cnt;
    // Sequencing of timeouts
    always @* begin
        nxt_state = state_ff;
        nxt_cnt = cnt_ff;
        nxt_ost_cnt = ost_cnt_ff;
        case (state_ff)
            `ST_HOLD: begin
                // Power-on detect leads here
                nxt_cnt = 32'h0000_0000;
                nxt_ost_cnt = 11'h000;
                if (powerup_timer_on) begin
                    nxt_state = `ST_PWRUP;
                end else if (crystal_mode) begin
                    nxt_state = `ST_OST;
                end else begin
                    nxt_state = `ST_RUN;
                end
            end
            `ST_PWRUP: begin
                // Delay runs even while the pin is low
                if (cnt_ff >= POWERUP_CYC - 1) begin
                    nxt_state = crystal_mode ? `ST_OST : `ST_RUN;
                end else begin
                    nxt_cnt = cnt_ff + 32'h0000_0001;
                end
            end
            `ST_OST: begin
                if (ost_cnt_ff >= OST_CYC - 1 && osc_rise) begin
                    nxt_state = `ST_RUN;
                end else if (osc_rise) begin
                    nxt_ost_cnt = ost_cnt_ff + 11'h001;
                end
            end
            `ST_BROWN: begin
                // Wait for supply, then a fresh power-up delay
                nxt_cnt = 32'h0000_0000;
                if (!brown_ff && !uv_agreed_ff) begin
                    nxt_state = `ST_PWRUP;
                end
            end
            `ST_SLEEP: begin
                // Crystal wake runs start-up count only
                nxt_ost_cnt = 11'h000;
                nxt_state = `ST_OST;
            end
            `ST_RUN: begin
                nxt_cnt = 32'h0000_0000;
                if ((wdt_wake || irq_wake) && crystal_mode) begin
                    nxt_state = `ST_SLEEP;
                end
            end
            default: begin
                nxt_state = `ST_HOLD;
            end
        endcase
        // A qualified dip restarts the power-up delay, also mid-delay; the start-up edge count is not cleared
        if (brown_ff) begin
            nxt_state = `ST_BROWN;
        end
    end

    always @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            state_ff <= `ST_HOLD;
            cnt_ff <= 32'h0000_0000;
            ost_cnt_ff <= 11'h000;
            clr_prev_ff <= 1'b1;
            osc_prev_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            cnt_ff <= nxt_cnt;
            ost_cnt_ff <= nxt_ost_cnt;
            clr_prev_ff <= clr_level_n;
            osc_prev_ff <= osc_agreed_ff;
        end
    end

    // ----------------------------------------
    // Reset outputs
    // ----------------------------------------
    // Pin low holds core; once timeouts expired, release is immediate
    assign core_reset = (state_ff != `ST_RUN) | ~clr_level_n;

    // ----------------------------------------
    // Cause and flags
    // ----------------------------------------
    reg [2:0] cause_ff;
    reg to_ff;
    reg pd_ff;
    reg por_ff;
    reg bor_ff;
    reg load_ff;     // Reset state load pulse
    reg keep_x_ff;   // Keep-class unknown since power-on
    reg wdt_hit_ff;  // Unused; never assigned or read
    wire brown_start = brown_ff & (state_ff != `ST_BROWN);
    // Flag updates by cause
    always @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            cause_ff <= C_POWERON;
            to_ff <= 1'b1;
            pd_ff <= 1'b1;
            por_ff <= 1'b0;
            bor_ff <= 1'b0;
            load_ff <= 1'b1;
            keep_x_ff <= 1'b1;
        end else begin
            load_ff <= 1'b0;
            if (brown_start) begin
                cause_ff <= C_BROWNOUT;
                to_ff <= 1'b1;
                pd_ff <= 1'b1;
                bor_ff <= 1'b0;
                load_ff <= 1'b1;
            end else if (wdt_reset) begin
                cause_ff <= C_WDT_RESET;
                to_ff <= 1'b0;
                pd_ff <= 1'b1;
                load_ff <= 1'b1;
            end else if (wdt_wake) begin
                // Wake resumes operation; no reset load
                cause_ff <= C_WDT_WAKE;
                to_ff <= 1'b0;
                pd_ff <= 1'b0;
            end else if (clr_sleep) begin
                cause_ff <= C_CLEAR_SLEEP;
                to_ff <= 1'b1;
                pd_ff <= 1'b0;
                load_ff <= 1'b1;
            end else if (irq_wake) begin
                cause_ff <= C_IRQ_WAKE;
                to_ff <= 1'b1;
                pd_ff <= 1'b0;
            end else if (clr_run) begin
                cause_ff <= C_CLEAR_RUN;
                load_ff <= 1'b1; // Flags unchanged
            end
            // Hardware clear wins over software set
            if (set_por_status) begin
                por_ff <= 1'b1;
                keep_x_ff <= 1'b0;
            end
            if (set_bor_status && !brown_start) begin
                bor_ff <= 1'b1;
            end
        end
    end

    assign reset_regs = load_ff;
    assign keep_regs_invalid = keep_x_ff;
    assign reset_cause = cause_ff;
    assign timeout_flag = to_ff;
    assign powerdown_flag = pd_ff;
    assign por_status = por_ff;
    assign bor_status = bor_ff;
endmodule
`default_nettype wire

//--- reset_seq_properties.sv
// Concurrent checks on the reset timeout sequencer ports
`timescale 1ns/100ps
`default_nettype none
module reset_seq_properties #(
    parameter FILTER_CYC = 4
) (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic master_clear_pin_n,
    input wire logic master_clear_pin_oe_n,
    input wire logic master_clear_pin_out,
    input wire logic undervoltage,
    input wire logic brownout_enable,
    input wire logic powerup_timer_en,
    input wire logic [1:0] osc_select_bits,
    input wire logic watchdog_timeout,
    input wire logic sleeping,
    input wire logic irq_wake,
    input wire logic core_reset,
    input wire logic reset_regs,
    input wire logic [2:0] reset_cause,
    input wire logic timeout_flag,
    input wire logic powerdown_flag,
    input wire logic por_status
);
    // ------------------------------------------------------------
    // Helper: cycles the pin has been low
    // ------------------------------------------------------------
    logic [5:0] low_cnt_ff;
    // Saturates, so a long hold never wraps back to zero
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            low_cnt_ff <= 6'h0;
        end else if (master_clear_pin_n) begin
            low_cnt_ff <= 6'h0;
        end else if (low_cnt_ff != 6'h3f) begin
            low_cnt_ff <= low_cnt_ff + 6'h1;
        end
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!nrst);
    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    property p_pin_quiet;
        master_clear_pin_oe_n && !master_clear_pin_out;
    endproperty
    a_pin_quiet: assert property (p_pin_quiet) else $error("clear pin driven");
    property p_por_vals;
        $rose(nrst) |-> core_reset && timeout_flag && powerdown_flag && !por_status && reset_cause == 3'h0;
    endproperty
    a_por_vals: assert property (p_por_vals) else $error("power-on values wrong");
    property p_hold;
        $rose(nrst) && (powerup_timer_en || brownout_enable) |-> core_reset [*8];
    endproperty
    a_hold: assert property (p_hold) else $error("power-up hold too short");
    property p_ost;
        $rose(nrst) && osc_select_bits != 2'b11 |-> core_reset [*8];
    endproperty
    a_ost: assert property (p_ost) else $error("start-up count skipped");
    property p_rc_fast;
        $rose(nrst) && !powerup_timer_en && !brownout_enable && osc_select_bits == 2'b11 |-> ##[1:8] !core_reset;
    endproperty
    a_rc_fast: assert property (p_rc_fast) else $error("release late");
    property p_held_low;
        low_cnt_ff >= FILTER_CYC + 6 |-> core_reset;
    endproperty
    a_held_low: assert property (p_held_low) else $error("pin low not held");
    property p_wdt;
        watchdog_timeout && !sleeping |=> reset_regs && !timeout_flag && powerdown_flag && reset_cause == 3'h3;
    endproperty
    a_wdt: assert property (p_wdt) else $error("watchdog reset wrong");
    property p_wake;
        watchdog_timeout && sleeping |=> !reset_regs && !timeout_flag && !powerdown_flag && reset_cause == 3'h4;
    endproperty
    a_wake: assert property (p_wake) else $error("watchdog wake wrong");
    property p_irq;
        irq_wake && sleeping && !watchdog_timeout |-> ##[1:3] timeout_flag && !powerdown_flag && reset_cause == 3'h6;
    endproperty
    a_irq: assert property (p_irq) else $error("interrupt wake wrong");
    property p_brown;
        brownout_enable && undervoltage [*8] ##1 undervoltage |-> ##2 core_reset && reset_cause == 3'h5;
    endproperty
    a_brown: assert property (p_brown) else $error("brown-out missed");
endmodule
`default_nettype wire

//--- supply_clear_model.sv
// Supply detector, clear-pin circuit and crystal around the sequencer
`timescale 1ns/100ps
`default_nettype none
module supply_clear_model (
    input wire logic core_clk,
    input wire logic press,
    input wire logic dip,
    input wire logic pin_oe_n,
    input wire logic pin_out,
    output wire logic master_clear_pin_n,
    output wire logic undervoltage,
    output wire logic osc_input_pin
);
    logic [1:0] div_ff = 2'h0; // Crystal divider
    // Pin has a pull-up; a driving sequencer would win over it
    assign master_clear_pin_n = pin_oe_n ? !press : (pin_out && !press);
    // Detector output follows the supply level directly
    assign undervoltage = dip;
    // Crystal runs free at a quarter of the core rate once powered
    always @(posedge core_clk) begin
        div_ff <= div_ff + 2'h1;
    end
    assign osc_input_pin = div_ff[1];
endmodule
`default_nettype wire

//--- testbench.sv
// Self-checking bench for the reset timeout sequencer
`timescale 1ns/100ps
`default_nettype none
`define CHK(got, exp) begin total_checks++; if ((got) !== (exp)) begin bad_count++; \
    $display("BAD t=%0t got=%h exp=%h", $time, got, exp); end end
module testbench;
    logic core_clk = 1'b0;
    logic nrst, press, dip, en, ebo, wd, slp, irq, spo, sbo, sample_req;
    logic [1:0] osc;
    wire pin_n, uv, osc_pin, oe_n, pin_out, core_reset, reset_regs, kv, to_o, pd_o, po_o, bo_o;
    wire [2:0] cause;
    logic [2:0] cz; // Expected cause and flags
    logic to_e, pd_e, po_e, bo_e, kv_e;
    logic [8:0] exp_q [$]; // Notes awaiting the monitor
    logic [8:0] exp_v; // Oldest note, popped once per compare
    logic [3:0] cfgs [4] = '{4'h3, 4'h6, 4'h9, 4'h0}; // {timer, brown, osc}
    integer seed = 6;
    int bad_count = 0;
    int total_checks = 0;
    int cycles = 0;
    reset_timeout_sequencer #(.POWERUP_CYC(20), .BROWNOUT_CYC(5), .OST_CYC(8), .FILTER_CYC(4))
    reset_timeout_sequencer_i (.core_clk(core_clk), .nrst(nrst), .master_clear_pin_n(pin_n),
        .master_clear_pin_oe_n(oe_n), .master_clear_pin_out(pin_out), .undervoltage(uv),
        .brownout_enable(ebo), .powerup_timer_en(en), .osc_select_bits(osc), .osc_input_pin(osc_pin),
        .watchdog_timeout(wd), .sleeping(slp), .irq_wake(irq), .set_por_status(spo), .set_bor_status(sbo),
        .core_reset(core_reset), .reset_regs(reset_regs), .keep_regs_invalid(kv), .reset_cause(cause),
        .timeout_flag(to_o), .powerdown_flag(pd_o), .por_status(po_o), .bor_status(bo_o));
    supply_clear_model supply_clear_model_i (.core_clk(core_clk), .press(press), .dip(dip), .pin_oe_n(oe_n),
        .pin_out(pin_out), .master_clear_pin_n(pin_n), .undervoltage(uv), .osc_input_pin(osc_pin));
    // ------------------------------------------------------------
    // Clock, hang guard and monitor
    // ------------------------------------------------------------
    initial begin
        forever #20 core_clk = ~core_clk;
    end
    // Whole run is under two thousand cycles; generous ceiling
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 5000) begin
            bad_count++;
            close_out();
        end
    end
    // Falling edge compare keeps clear of rising-edge updates
    always @(negedge core_clk) begin
        if (sample_req && exp_q.size() > 0) begin
            // Pop first: the macro names its expected value twice
            exp_v = exp_q.pop_front();
            `CHK({cause, to_o, pd_o, po_o, bo_o, kv, core_reset}, exp_v)
        end
    end
    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task tick(input int n);
        repeat (n) @(posedge core_clk);
    endtask
    task note(input logic cr);
        exp_q.push_back({cz, to_e, pd_e, po_e, bo_e, kv_e, cr});
        sample_req <= 1'b1;
        tick(1);
        sample_req <= 1'b0;
    endtask
    // Bounded wait; a stuck reset shows up at the next note
    task wait_rel;
        repeat (300) begin
            @(negedge core_clk);
            if (core_reset === 1'b0) break;
        end
        tick(1);
    endtask
    task pon(input logic [3:0] c);
        nrst <= 1'b0;
        {en, ebo, osc} <= c;
        tick(20);
        nrst <= 1'b1;
        {cz, to_e, pd_e, po_e, bo_e, kv_e} = 8'h19;
        tick(8);
        note(c[3] | c[2] | (c[1:0] != 2'b11));
        wait_rel;
        note(1'b0);
    endtask
    task close_out;
        $display("Counts: checks=%0d bad=%0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        {nrst, press, dip, en, ebo, wd, slp, irq, spo, sbo, sample_req} = 11'h0;
        osc = 2'b11;
        // Every oscillator code, timer on/off, brown-out forcing
        for (int i = 0; i < 4; i++) begin
            pon(cfgs[i]);
        end
        $display("Test power-on sequences done");
        spo <= 1'b1;
        sbo <= 1'b1;
        tick(1);
        {spo, sbo} <= 2'b00;
        tick(2);
        {po_e, bo_e, kv_e} = 3'b110;
        note(1'b0);
        press <= 1'b1;
        tick(1 + $unsigned($random(seed)) % 3);
        press <= 1'b0;
        tick(20);
        note(1'b0);
        press <= 1'b1;
        tick(40);
        cz = 3'h1;
        note(1'b1);
        press <= 1'b0;
        tick(12);
        note(1'b0);
        $display("Test clear pin done");
        wd <= 1'b1;
        tick(1);
        wd <= 1'b0;
        {cz, to_e, pd_e} = 5'h0d;
        wait_rel;
        note(1'b0);
        slp <= 1'b1;
        tick(1);
        wd <= 1'b1;
        tick(1);
        wd <= 1'b0;
        {cz, to_e, pd_e} = 5'h10;
        wait_rel;
        slp <= 1'b0;
        note(1'b0);
        $display("Test watchdog done");
        slp <= 1'b1;
        press <= 1'b1;
        tick(20);
        press <= 1'b0;
        {cz, to_e, pd_e} = 5'h0a;
        wait_rel;
        slp <= 1'b0;
        note(1'b0);
        slp <= 1'b1;
        tick(1);
        irq <= 1'b1;
        tick(1);
        irq <= 1'b0;
        {cz, to_e, pd_e} = 5'h1a;
        wait_rel;
        slp <= 1'b0;
        note(1'b0);
        $display("Test sleep wake done");
        ebo <= 1'b1;
        tick(2);
        dip <= 1'b1;
        tick(1 + $unsigned($random(seed)) % 3);
        dip <= 1'b0;
        tick(20);
        note(1'b0);
        dip <= 1'b1;
        tick(30);
        {cz, to_e, pd_e} = 5'h17;
        bo_e = 1'b0;
        note(1'b1);
        dip <= 1'b0;
        tick(10);
        dip <= 1'b1;
        tick(30);
        dip <= 1'b0;
        // Late enough that an ignored dip would already have released
        tick(24);
        note(1'b1);
        wait_rel;
        note(1'b0);
        $display("Test brown-out done");
        close_out();
    end
endmodule
bind reset_timeout_sequencer reset_seq_properties #(.FILTER_CYC(FILTER_CYC)) reset_seq_properties_i (
    .core_clk(core_clk), .nrst(nrst), .master_clear_pin_n(master_clear_pin_n),
    .master_clear_pin_oe_n(master_clear_pin_oe_n), .master_clear_pin_out(master_clear_pin_out),
    .undervoltage(undervoltage), .brownout_enable(brownout_enable), .powerup_timer_en(powerup_timer_en),
    .osc_select_bits(osc_select_bits), .watchdog_timeout(watchdog_timeout), .sleeping(sleeping),
    .irq_wake(irq_wake), .core_reset(core_reset), .reset_regs(reset_regs), .reset_cause(reset_cause),
    .timeout_flag(timeout_flag), .powerdown_flag(powerdown_flag), .por_status(por_status));
`default_nettype wire
